// [hdl/sro_sys.sv]
// Wakeup timer, divided clock output and part identification registers
// Function
// - Pin enable drives divided clock onto pin
// - Output frequency is bus clock over 2N
// - Zero divide with enable holds pin low
// - Twelve-bit part number split over two registers
// - High id reserved bits ignore writes
// - Timer timeout sets read-only flag
// - Writing acknowledge one clears flag
// - Clock select picks internal or external
// - Enable bit gates wakeup_irq only; irq has its own enable register
// - Delay select zero disables timer
// - Internal delays 8 ms to 1.024 s
// - External delays divide by 256 to 32768
// - Internal tick free-running near 1 kHz
// - Unimplemented status bits read zero
`timescale 1ns/1ps
`default_nettype none
`include "sro_regs.svh"
module sro_sys #(
    parameter int TICK_CYC = `SRO_TICK_CYC,
    parameter logic [11:0] PART_ID = `SRO_PART_ID // Arbitrary value
)(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire sro_pkg::sro_bus_s bus,
    output logic [7:0] rdata,
    // External crystal clock enable pulse, one cycle per crystal period
    input wire logic xtal_tick,
    // Clock output pin, enable low while driving
    output logic port_c_bit2_pin_o,
    output logic port_c_bit2_pin_oe_n,
    // Interrupts
    output logic wakeup_irq,
    output logic irq
);
    logic [7:0] clkout_ctrl_r;
    logic [2:0] wake_sel_r;
    logic wakeup_clock_select_r;
    logic wakeup_interrupt_enable_r;
    logic wakeup_timeout_flag_r;
    logic irq_status_r;
    logic irq_enable_r;
    logic [15:0] osc_cnt_r;
    logic osc_tick;
    logic [15:0] wake_cnt_r;
    logic [15:0] wake_limit;
    logic wake_src_tick;
    logic timeout;
    logic [2:0] div_cnt_r;
    logic clk_pin_r;
    logic wr_clk, wr_wake, wr_clr, wr_en;
    logic [2:0] clkout_divide_select;
    logic clkout_pin_enable;

    assign wr_clk = bus.wr && bus.addr == `SRO_OFF_CLKOUT_CTRL;
    assign wr_wake = bus.wr && bus.addr == `SRO_OFF_WAKE_SC;
    assign wr_clr = bus.wr && bus.addr == `SRO_OFF_IRQ_CLEAR;
    assign wr_en = bus.wr && bus.addr == `SRO_OFF_IRQ_ENABLE;
    assign clkout_divide_select = clkout_ctrl_r[2:0];
    assign clkout_pin_enable = clkout_ctrl_r[`SRO_BIT_PIN_EN];

    // Clock output control register, only implemented bits kept
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            clkout_ctrl_r <= `SRO_CLKOUT_RST;
        else if (wr_clk)
            clkout_ctrl_r <= bus.wdata & 8'h17;
    end

    // Wakeup control fields
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wake_sel_r <= 3'h0;
            wakeup_clock_select_r <= 1'b0;
            wakeup_interrupt_enable_r <= 1'b0;
        end
        else if (wr_wake)
        begin
            wake_sel_r <= bus.wdata[2:0];
            wakeup_clock_select_r <= bus.wdata[`SRO_BIT_WCLKSEL];
            wakeup_interrupt_enable_r <= bus.wdata[`SRO_BIT_WIE];
        end
    end

    // Free-running internal tick, never reset by control writes
    // free-running tick
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            osc_cnt_r <= 16'h0000;
        else if (osc_cnt_r == 16'(TICK_CYC - 1))
            osc_cnt_r <= 16'h0000;
        else
            osc_cnt_r <= osc_cnt_r + 16'h0001;
    end
    assign osc_tick = osc_cnt_r == 16'(TICK_CYC - 1);

    // Source and period table
    // source select
    always_comb
    begin
        wake_src_tick = wakeup_clock_select_r ? xtal_tick : osc_tick;
        wake_limit = 16'h0000;
        if (!wakeup_clock_select_r)
        begin
            case (wake_sel_r)
                3'h1: wake_limit = 16'd8;
                3'h2: wake_limit = 16'd32;
                3'h3: wake_limit = 16'd64;
                3'h4: wake_limit = 16'd128;
                3'h5: wake_limit = 16'd256;
                3'h6: wake_limit = 16'd512;
                3'h7: wake_limit = 16'd1024;
                default: wake_limit = 16'h0000;
            endcase
        end
        else
        begin
            case (wake_sel_r)
                3'h1: wake_limit = 16'd256;
                3'h2: wake_limit = 16'd1024;
                3'h3: wake_limit = 16'd2048;
                3'h4: wake_limit = 16'd4096;
                3'h5: wake_limit = 16'd8192;
                3'h6: wake_limit = 16'd16384;
                3'h7: wake_limit = 16'd32768;
                default: wake_limit = 16'h0000;
            endcase
        end
    end

    // Wakeup counter, held at zero when disabled or reconfigured
    // zero disables
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            wake_cnt_r <= 16'h0000;
        else if (wake_sel_r == 3'h0 || wr_wake)
            wake_cnt_r <= 16'h0000;
        else if (wake_src_tick)
            wake_cnt_r <= timeout ? 16'h0000 : wake_cnt_r + 16'h0001;
    end
    assign timeout = wake_sel_r != 3'h0 && wake_src_tick && wake_cnt_r == wake_limit - 16'h0001;

    // Timeout flag, set wins over acknowledge
    // set on timeout
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            wakeup_timeout_flag_r <= 1'b0;
        else if (timeout)
            wakeup_timeout_flag_r <= 1'b1;
        else if (wr_wake && bus.wdata[`SRO_BIT_WACK])
            wakeup_timeout_flag_r <= 1'b0;
    end

    assign wakeup_irq = wakeup_timeout_flag_r && wakeup_interrupt_enable_r;

    // Block interrupt status, clear and enable
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            irq_status_r <= 1'b0;
            irq_enable_r <= 1'b0;
        end
        else
        begin
            if (timeout)
                irq_status_r <= 1'b1;
            else if (wr_clr && bus.wdata[0])
                irq_status_r <= 1'b0;
            if (wr_en)
                irq_enable_r <= bus.wdata[0];
        end
    end
    assign irq = irq_status_r && irq_enable_r;

    // Clock output divider, toggles every N bus cycles
    // divide by 2N
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            div_cnt_r <= 3'h0;
            clk_pin_r <= 1'b0;
        end
        else if (clkout_divide_select == 3'h0 || !clkout_pin_enable)
        begin
            div_cnt_r <= 3'h0;
            clk_pin_r <= 1'b0;
        end
        else if (div_cnt_r >= clkout_divide_select - 3'h1)
        begin
            div_cnt_r <= 3'h0;
            clk_pin_r <= ~clk_pin_r;
        end
        else
            div_cnt_r <= div_cnt_r + 3'h1;
    end

    assign port_c_bit2_pin_o = clk_pin_r;
    assign port_c_bit2_pin_oe_n = ~clkout_pin_enable;

    // Read data, one cycle after the strobe
    // part number
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            rdata <= 8'h00;
        else if (bus.rd)
        begin
            case (bus.addr)
                `SRO_OFF_CLKOUT_CTRL: rdata <= clkout_ctrl_r;
                `SRO_OFF_PART_ID_HI: rdata <= {4'h0, PART_ID[11:8]};
                `SRO_OFF_PART_ID_LO: rdata <= PART_ID[7:0];
                `SRO_OFF_WAKE_SC: rdata <= {wakeup_timeout_flag_r, 1'b0, wakeup_clock_select_r,
                    wakeup_interrupt_enable_r, 1'b0, wake_sel_r};
                `SRO_OFF_IRQ_STATUS: rdata <= {7'h00, irq_status_r};
                `SRO_OFF_IRQ_ENABLE: rdata <= {7'h00, irq_enable_r};
                default: rdata <= 8'h00;
            endcase
        end
        else
            rdata <= 8'h00;
    end

    // Assertions guarding the wakeup flag, the divider and the read port

    a_flag_sets: assert property (@(posedge mclk) disable iff (rst)
        timeout |=> wakeup_timeout_flag_r) else $error("flag not set");

    a_ack_clears: assert property (@(posedge mclk) disable iff (rst)
        wr_wake && bus.wdata[6] && !timeout |=> !wakeup_timeout_flag_r) else $error("ack");

    a_flag_sticky: assert property (@(posedge mclk) disable iff (rst)
        wakeup_timeout_flag_r && !wr_wake |=> wakeup_timeout_flag_r) else $error("sticky");

    a_irq_gate: assert property (@(posedge mclk) disable iff (rst)
        wakeup_irq == (wakeup_timeout_flag_r && wakeup_interrupt_enable_r)) else $error("irq");

    a_timer_off: assert property (@(posedge mclk) disable iff (rst)
        wake_sel_r == 3'h0 |-> !timeout) else $error("disabled timer fired");

    a_pin_low: assert property (@(posedge mclk) disable iff (rst)
        clkout_pin_enable && clkout_divide_select == 3'h0 |=> !port_c_bit2_pin_o)
        else $error("pin not low");

    a_pin_drive: assert property (@(posedge mclk) disable iff (rst)
        port_c_bit2_pin_oe_n == !clkout_pin_enable) else $error("pin enable");

    a_div_one: assert property (@(posedge mclk) disable iff (rst)
        clkout_pin_enable && clkout_divide_select == 3'h1 && $stable(clkout_ctrl_r)
        && $past(clkout_pin_enable) && $past(clkout_divide_select) == 3'h1
        |=> port_c_bit2_pin_o != $past(port_c_bit2_pin_o)) else $error("div");

    a_id_high: assert property (@(posedge mclk) disable iff (rst)
        bus.rd && bus.addr == `SRO_OFF_PART_ID_HI |=> rdata == {4'h0, PART_ID[11:8]})
        else $error("id high");

    a_wsc_zero: assert property (@(posedge mclk) disable iff (rst)
        bus.rd && bus.addr == `SRO_OFF_WAKE_SC |=> rdata[6] == 1'b0 && rdata[3] == 1'b0)
        else $error("zero bits");

    // low id byte
    // The low register carries the whole lower byte of the part number
    a_id_low: assert property (@(posedge mclk) disable iff (rst)
        bus.rd && bus.addr == `SRO_OFF_PART_ID_LO |=> rdata == PART_ID[7:0])
        else $error("id low");

    // reserved bits quiet
    // Reserved nibble reads as zero here, whatever was written before
    a_id_reserved: assert property (@(posedge mclk) disable iff (rst)
        bus.rd && bus.addr == `SRO_OFF_PART_ID_HI |=> rdata[7:4] == 4'h0)
        else $error("id reserved");

    // no set without timeout
    // Software has no path that raises the flag
    a_flag_no_write: assert property (@(posedge mclk) disable iff (rst)
        !wakeup_timeout_flag_r && !timeout |=> !wakeup_timeout_flag_r)
        else $error("flag set without timeout");

    // source select held
    // The source only changes on a write to the wakeup register
    a_clksel_hold: assert property (@(posedge mclk) disable iff (rst)
        !wr_wake |=> $stable(wakeup_clock_select_r))
        else $error("clock select moved");

    // internal source ticks
    // With the internal source selected only internal ticks end a period
    a_src_internal: assert property (@(posedge mclk) disable iff (rst)
        !wakeup_clock_select_r && timeout |-> osc_tick)
        else $error("internal timeout off tick");

    // external source ticks
    // With the external source selected only crystal pulses end a period
    a_src_external: assert property (@(posedge mclk) disable iff (rst)
        wakeup_clock_select_r && timeout |-> xtal_tick)
        else $error("external timeout off pulse");

    // enable held
    // The interrupt enable only changes on a write to the wakeup register
    a_ie_hold: assert property (@(posedge mclk) disable iff (rst)
        !wr_wake |=> $stable(wakeup_interrupt_enable_r))
        else $error("interrupt enable moved");

    // request has a cause
    // A new request follows a timeout or a write that turns the enable on
    a_irq_cause: assert property (@(posedge mclk) disable iff (rst)
        $rose(wakeup_irq) |-> $past(timeout) || $past(wr_wake && bus.wdata[`SRO_BIT_WIE]))
        else $error("request without cause");

    // internal tick bounded
    // The free-running counter never passes its wrap value
    a_osc_bound: assert property (@(posedge mclk) disable iff (rst)
        osc_cnt_r <= 16'(TICK_CYC - 1))
        else $error("tick counter overrun");

    // period counter bounded
    // A running period never counts past its selected length
    a_cnt_bound: assert property (@(posedge mclk) disable iff (rst)
        wake_sel_r != 3'h0 |-> wake_cnt_r < wake_limit)
        else $error("period counter overrun");

    // disabled pin idles low
    // A disabled output leaves the divider flop parked at zero
    a_pin_off: assert property (@(posedge mclk) disable iff (rst)
        !clkout_pin_enable |=> !port_c_bit2_pin_o)
        else $error("disabled pin moving");

    // only control bits kept
    // Bits outside the enable and the divide field never store a one
    a_clk_mask: assert property (@(posedge mclk) disable iff (rst)
        (clkout_ctrl_r & 8'he8) == 8'h00)
        else $error("control spare bit set");

    // read data idles zero
    // Read data stand for one cycle only and are zero otherwise
    a_rdata_idle: assert property (@(posedge mclk) disable iff (rst)
        !bus.rd |=> rdata == 8'h00)
        else $error("read data not idle");
endmodule
`default_nettype wire

// [hdl/sro_regs.svh]
// Register offsets, field positions, reset values and timing counts for the system block
`ifndef SRO_REGS_SVH
`define SRO_REGS_SVH
`define SRO_OFF_CLKOUT_CTRL 4'h0
`define SRO_OFF_PART_ID_HI 4'h1
`define SRO_OFF_PART_ID_LO 4'h2
`define SRO_OFF_WAKE_SC 4'h3
`define SRO_OFF_IRQ_STATUS 4'h4
`define SRO_OFF_IRQ_CLEAR 4'h5
`define SRO_OFF_IRQ_ENABLE 4'h6
`define SRO_BIT_PIN_EN 4
`define SRO_BIT_WFLAG 7
`define SRO_BIT_WACK 6
`define SRO_BIT_WCLKSEL 5
`define SRO_BIT_WIE 4
`define SRO_CLKOUT_RST 8'h00
`define SRO_WAKE_RST 8'h00
`define SRO_PART_ID 12'h5a3
`define SRO_TICK_US 1000
`define SRO_CLK_MHZ 40
`define SRO_TICK_CYC (`SRO_TICK_US * `SRO_CLK_MHZ)
`endif

// [hdl/sro_pkg.sv]
// Types shared by the system block
package sro_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sro_bus_s;
endpackage

// [sim/tb_top.sv]
// Self-checking bench for the wakeup timer, clock output and part id block
`timescale 1ns/1ps
`default_nettype none
`include "sro_regs.svh"
module tb_top;
    localparam int TK = 4;
    localparam logic [11:0] PID = 12'h3c7; // Arbitrary value
    logic mclk;
    logic rst;
    sro_pkg::sro_bus_s bus;
    logic [7:0] rdata;
    logic xtal_tick;
    logic pin_o;
    logic pin_oe_n;
    logic wakeup_irq;
    logic irq;
    int n_mismatch = 0;
    int check_count = 0;
    logic [7:0] d;
    logic [7:0] v;
    int p;
    sro_sys #(.TICK_CYC(TK), .PART_ID(PID)) i_dut (
        .mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata), .xtal_tick(xtal_tick),
        .port_c_bit2_pin_o(pin_o), .port_c_bit2_pin_oe_n(pin_oe_n),
        .wakeup_irq(wakeup_irq), .irq(irq));
    // Compare and count
    task check(input logic [7:0] seen, input logic [7:0] exp);
        begin
            check_count++;
            if (seen !== exp)
            begin
                n_mismatch++;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task finish_test;
        begin
            $display("Comparisons %0d mismatches %0d", check_count, n_mismatch);
            if (n_mismatch == 0 && check_count > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // Register port cycles, strobes one cycle long
    task wr(input logic [3:0] a, input logic [7:0] w);
        begin
            @(posedge mclk);
            bus <= '{a, w, 1'b1, 1'b0};
            @(posedge mclk);
            bus.wr <= 1'b0;
            // Let the write settle before any check looks at outputs
            #1;
        end
    endtask
    task rd(input logic [3:0] a, output logic [7:0] r);
        begin
            @(posedge mclk);
            bus <= '{a, 8'h00, 1'b0, 1'b1};
            @(posedge mclk);
            bus.rd <= 1'b0;
            #1 r = rdata;
        end
    endtask
    // Expected timeout periods in clock cycles
    function automatic int t_int(input int c);
        return (c == 1) ? 8 * TK : (1 << (c + 3)) * TK;
    endfunction
    function automatic int t_ext(input int c);
        return (c == 1) ? 256 : (1 << (c + 8));
    endfunction
    // Cycles between two rising edges of the pin, 0 if none
    task clk_period(output int per);
        int t0;
        logic last;
        begin
            t0 = -1;
            per = 0;
            last = pin_o;
            for (int n = 0; n < 64 && per == 0; n++)
            begin
                @(posedge mclk);
                #1;
                if (pin_o === 1'b1 && last === 1'b0)
                begin
                    if (t0 < 0)
                        t0 = n;
                    else
                        per = n - t0;
                end
                last = pin_o;
            end
        end
    endtask
    // Interrupt stays low before the period ends and is high just after
    task wake(input logic [7:0] sc, input int per);
        begin
            wr(`SRO_OFF_WAKE_SC, sc);
            repeat (per - TK - 4) @(posedge mclk);
            check({7'h0, wakeup_irq}, 8'h00);
            repeat (2 * TK + 8) @(posedge mclk);
            check({7'h0, wakeup_irq}, 8'h01);
        end
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Watchdog against a hang
    initial
    begin
        repeat (40000) @(posedge mclk);
        n_mismatch++;
        finish_test();
    end
    initial
    begin
        rst = 1'b1;
        bus = '0;
        xtal_tick = 1'b0;
        void'($urandom(32'hde10d4f1));
        repeat (16) @(posedge mclk);
        check({7'h0, pin_oe_n}, 8'h01);
        rst <= 1'b0;
        // Identification, read-only writes, unmapped read
        wr(`SRO_OFF_PART_ID_HI, 8'($urandom));
        wr(`SRO_OFF_PART_ID_LO, 8'($urandom));
        rd(`SRO_OFF_PART_ID_HI, d);
        check(d, {4'h0, PID[11:8]});
        rd(`SRO_OFF_PART_ID_LO, d);
        check(d, PID[7:0]);
        rd(4'(7 + $urandom % 9), d);
        check(d, 8'h00);
        rd(`SRO_OFF_WAKE_SC, d);
        check(d, `SRO_WAKE_RST);
        // Delay zero with random upper bits: no flag, no timeout
        v = (8'($urandom) & 8'hf8) | 8'h10;
        xtal_tick <= 1'b1;
        wr(`SRO_OFF_WAKE_SC, v);
        repeat (300) @(posedge mclk);
        check({7'h0, wakeup_irq}, 8'h00);
        rd(`SRO_OFF_WAKE_SC, d);
        check(d, v & 8'h30);
        xtal_tick <= 1'b0;
        $display("test ident done");
        // Divided clock for every nonzero divide, then zero divide
        for (int k = 1; k < 8; k++)
        begin
            wr(`SRO_OFF_CLKOUT_CTRL, 8'h10 | 8'(k));
            check({7'h0, pin_oe_n}, 8'h00);
            clk_period(p);
            check(8'(p), 8'(2 * k));
        end
        v = 8'($urandom);
        wr(`SRO_OFF_CLKOUT_CTRL, v);
        rd(`SRO_OFF_CLKOUT_CTRL, d);
        check(d, v & 8'h17);
        wr(`SRO_OFF_CLKOUT_CTRL, 8'h10);
        repeat (3) @(posedge mclk);
        clk_period(p);
        check({pin_oe_n, pin_o, 6'(p)}, 8'h00);
        wr(`SRO_OFF_CLKOUT_CTRL, 8'h03);
        check({7'h0, pin_oe_n}, 8'h01);
        $display("test clkout done");
        // Internal source, every delay code
        for (int c = 1; c < 8; c++)
        begin
            wake(8'h50 | 8'(c), t_int(c));
        end
        wake(8'h51, t_int(1));
        repeat (2 * t_int(1)) @(posedge mclk);
        check({7'h0, wakeup_irq}, 8'h01);
        wr(`SRO_OFF_WAKE_SC, 8'h11);
        check({7'h0, wakeup_irq}, 8'h01);
        rd(`SRO_OFF_WAKE_SC, d);
        check(d, 8'h91);
        // Block interrupt raised, masked, cleared
        wr(`SRO_OFF_IRQ_ENABLE, 8'h01);
        check({7'h0, irq}, 8'h01);
        wr(`SRO_OFF_IRQ_ENABLE, 8'h00);
        check({7'h0, irq}, 8'h00);
        wr(`SRO_OFF_WAKE_SC, 8'h40);
        check({7'h0, wakeup_irq}, 8'h00);
        rd(`SRO_OFF_WAKE_SC, d);
        check(d, 8'h00);
        rd(`SRO_OFF_IRQ_STATUS, d);
        check(d, 8'h01);
        wr(`SRO_OFF_IRQ_CLEAR, 8'h01);
        rd(`SRO_OFF_IRQ_STATUS, d);
        check(d, 8'h00);
        wr(`SRO_OFF_IRQ_ENABLE, 8'h01);
        check({7'h0, irq}, 8'h00);
        // Enable off: flag sets, request blocked
        wr(`SRO_OFF_WAKE_SC, 8'h01);
        repeat (t_int(1) + TK + 8) @(posedge mclk);
        check({7'h0, wakeup_irq}, 8'h00);
        rd(`SRO_OFF_WAKE_SC, d);
        check(d, 8'h81);
        $display("test internal done");
        // External source ignores internal ticks
        wr(`SRO_OFF_WAKE_SC, 8'h71);
        repeat (t_int(1) + TK + 8) @(posedge mclk);
        check({7'h0, wakeup_irq}, 8'h00);
        xtal_tick <= 1'b1;
        wake(8'h71, t_ext(1));
        wake(8'h72, t_ext(2));
        $display("test external done");
        finish_test();
    end
endmodule
`default_nettype wire
